// *** common/tx_lane_map.svh ***
// Offsets, field positions and reset values of the lane tuning registers.
// Assumes byte address = 4 x register index on the register bus.
`ifndef TX_LANE_MAP_SVH
`define TX_LANE_MAP_SVH

`define IDX_DRIVE_CTL      16'h0027
`define IDX_DEEMPH_CTL     16'h002C
`define IDX_MACRO1_CTL     16'h7EC0
`define IDX_MACRO2_CTL     16'h7EC4
`define IDX_MACRO3_CTL     16'h7EC8

`define RST_DRIVE_CTL      32'h0000_0000
`define RST_DEEMPH_CTL     32'h0000_0000
`define RST_MACRO1_CTL     32'h0000_0000
`define RST_MACRO2_CTL     32'h0000_0000
`define RST_MACRO3_CTL     32'h0000_0000

`define DRV_LANE0_LSB      16
`define DRV_LANES4TO7_LSB  18
`define DRV_LANES8TO15_LSB 20
`define DRV_CODE_W         2
`define DRV_STRONGEST      2'h3

`define DEN_LANE0_BIT      24
`define DEN_LANES4TO7_BIT  25
`define DEN_LANES8TO15_BIT 26
`define DLV_LANE0_LSB      0
`define DLV_LANES4TO7_LSB  8
`define DLV_LANES8TO15_LSB 16

`define M1_DRV_LSB         4
`define M1_DRV_W           12
`define M1_DEN_BIT         20
`define M2_DRV_LSB         16
`define M2_DLV_HI_LSB      12
`define M2_DLV_LO_LSB      4
`define M3_DRV_LSB         16
`define M3_DEN2_BIT        28
`define M3_DLV_HI_LSB      8
`define M3_DLV_LO_BIT      0

`define RESP_OKAY          2'h0
`define RESP_DECODEERROR   2'h3

`endif

// *** common/tx_lane_pkg.sv ***
// Types shared by the lane tuning register bank and its bus front end.
// Assumes tx_lane_map.svh supplies the numeric layout.
package tx_lane_pkg;

  typedef struct packed {
    logic        deemph_on;
    logic [7:0]  deemph_level;
    logic [1:0]  drive_code;
  } lane_tune_t;

  typedef struct packed {
    logic        wr_en;
    logic        rd_en;
    logic [15:0] idx;
    logic [31:0] wdata;
    logic [3:0]  be;
  } reg_req_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_DONE = 3'b100
  } bus_state_t;

endpackage

// *** logic/avalon_reg_slave.sv ***
// Avalon-MM slave front end: two wait states, registered read data.
// Assumes a master that holds its request until waitrequest is low.
`timescale 1ns/100ps
`default_nettype none
`include "tx_lane_map.svh"

module avalon_reg_slave (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire logic [17:0]          address,
  input  wire logic                 read,
  input  wire logic                 write,
  input  wire logic [3:0]           byteenable,
  input  wire logic [31:0]          writedata,
  output logic      [31:0]          readdata,
  output logic      [1:0]           response,
  output logic                      waitrequest,
  output tx_lane_pkg::reg_req_t     req,
  input  wire logic [31:0]          rdata,
  input  wire logic                 hit
);

  tx_lane_pkg::bus_state_t state_reg;
  logic [31:0]             readdata_reg;
  logic [1:0]              response_reg;

  // Read data is latched in WAIT so it already stands in DONE, the
  // answer cycle; writes land at the DONE edge, where the master sees it
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg <= tx_lane_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        tx_lane_pkg::ST_IDLE: begin
          if (read || write) begin
            state_reg <= tx_lane_pkg::ST_WAIT;
          end
        end
        tx_lane_pkg::ST_WAIT: state_reg <= tx_lane_pkg::ST_DONE;
        tx_lane_pkg::ST_DONE: state_reg <= tx_lane_pkg::ST_IDLE;
        default:              state_reg <= tx_lane_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      readdata_reg <= 32'h0000_0000;
      response_reg <= `RESP_OKAY;
    end else if (state_reg == tx_lane_pkg::ST_WAIT) begin
      readdata_reg <= read ? rdata : 32'h0000_0000;
      response_reg <= hit ? `RESP_OKAY : `RESP_DECODEERROR;
    end
  end

  assign waitrequest = (read || write) &&
                       (state_reg != tx_lane_pkg::ST_DONE);
  assign readdata    = readdata_reg;
  assign response    = response_reg;

  always_comb begin
    req       = '0;
    req.idx   = address[17:2];
    req.wdata = writedata;
    req.be    = byteenable;
    req.rd_en = read && (state_reg == tx_lane_pkg::ST_DONE);
    req.wr_en = write && (state_reg == tx_lane_pkg::ST_DONE);
  end

endmodule

`default_nettype wire

// *** logic/tx_lane_tuning_regs.sv ***
// Transmitter lane tuning register bank with static PHY control outputs.
// Assumes one clock, synchronous reset, Avalon-MM master with waitrequest.
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "tx_lane_map.svh"

module tx_lane_tuning_regs (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire logic [17:0]          address,
  input  wire logic                 read,
  input  wire logic                 write,
  input  wire logic [3:0]           byteenable,
  input  wire logic [31:0]          writedata,
  output logic      [31:0]          readdata,
  output logic      [1:0]           response,
  output logic                      waitrequest,
  output tx_lane_pkg::lane_tune_t   lane0_tune,
  output tx_lane_pkg::lane_tune_t   lanes4to7_tune,
  output tx_lane_pkg::lane_tune_t   lanes8to15_tune,
  output logic      [11:0]          lane1_drive_code,
  output logic                      lane1_deemph_on,
  output logic      [7:0]           lane1_deemph_level,
  output logic      [1:0]           lane2_drive_code,
  output logic                      lane2_deemph_on,
  output logic      [7:0]           lane2_deemph_level,
  output logic      [1:0]           lane3_drive_code,
  output logic      [7:0]           lane3_deemph_level
);

  tx_lane_pkg::reg_req_t req;
  logic [31:0]           rdata;
  logic                  hit;
  logic [31:0]           drive_ctl_reg;
  logic [31:0]           deemph_ctl_reg;
  logic [31:0]           macro1_ctl_reg;
  logic [31:0]           macro2_ctl_reg;
  logic [31:0]           macro3_ctl_reg;

  avalon_reg_slave u_slave (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .address     (address),
    .read        (read),
    .write       (write),
    .byteenable  (byteenable),
    .writedata   (writedata),
    .readdata    (readdata),
    .response    (response),
    .waitrequest (waitrequest),
    .req         (req),
    .rdata       (rdata),
    .hit         (hit)
  );

  // Merge only enabled byte lanes so neighbouring fields stay intact
  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0]  be
  );
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic is_write(
    input tx_lane_pkg::reg_req_t r,
    input logic [15:0]           idx
  );
    return r.wr_en && (r.idx == idx);
  endfunction

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      drive_ctl_reg <= `RST_DRIVE_CTL;
    end else if (is_write(req, `IDX_DRIVE_CTL)) begin
      drive_ctl_reg <= merge_bytes(drive_ctl_reg, req.wdata, req.be);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      deemph_ctl_reg <= `RST_DEEMPH_CTL;
    end else if (is_write(req, `IDX_DEEMPH_CTL)) begin
      deemph_ctl_reg <= merge_bytes(deemph_ctl_reg, req.wdata, req.be);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      macro1_ctl_reg <= `RST_MACRO1_CTL;
    end else if (is_write(req, `IDX_MACRO1_CTL)) begin
      macro1_ctl_reg <= merge_bytes(macro1_ctl_reg, req.wdata, req.be);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      macro2_ctl_reg <= `RST_MACRO2_CTL;
    end else if (is_write(req, `IDX_MACRO2_CTL)) begin
      macro2_ctl_reg <= merge_bytes(macro2_ctl_reg, req.wdata, req.be);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      macro3_ctl_reg <= `RST_MACRO3_CTL;
    end else if (is_write(req, `IDX_MACRO3_CTL)) begin
      macro3_ctl_reg <= merge_bytes(macro3_ctl_reg, req.wdata, req.be);
    end
  end

  // Whole words read back; unmapped indices read zero and flag an error
  always_comb begin
    rdata = 32'h0000_0000;
    hit   = 1'b1;
    case (req.idx)
      `IDX_DRIVE_CTL:  rdata = drive_ctl_reg;
      `IDX_DEEMPH_CTL: rdata = deemph_ctl_reg;
      `IDX_MACRO1_CTL: rdata = macro1_ctl_reg;
      `IDX_MACRO2_CTL: rdata = macro2_ctl_reg;
      `IDX_MACRO3_CTL: rdata = macro3_ctl_reg;
      default:         hit   = 1'b0;
    endcase
  end

  // Misc-space lanes: lane 0 and the two lane groups
  always_comb begin
    lane0_tune.drive_code =
      drive_ctl_reg[`DRV_LANE0_LSB +: `DRV_CODE_W];
    lanes4to7_tune.drive_code =
      drive_ctl_reg[`DRV_LANES4TO7_LSB +: `DRV_CODE_W];
    lanes8to15_tune.drive_code =
      drive_ctl_reg[`DRV_LANES8TO15_LSB +: `DRV_CODE_W];
    lane0_tune.deemph_on      = deemph_ctl_reg[`DEN_LANE0_BIT];
    lanes4to7_tune.deemph_on  = deemph_ctl_reg[`DEN_LANES4TO7_BIT];
    lanes8to15_tune.deemph_on = deemph_ctl_reg[`DEN_LANES8TO15_BIT];
    lane0_tune.deemph_level =
      deemph_ctl_reg[`DLV_LANE0_LSB +: 8];
    lanes4to7_tune.deemph_level =
      deemph_ctl_reg[`DLV_LANES4TO7_LSB +: 8];
    lanes8to15_tune.deemph_level =
      deemph_ctl_reg[`DLV_LANES8TO15_LSB +: 8];
  end

  // Display macro lanes; lane 1 drive overlaps its strength slices,
  // so bits 13:12 and 9:8 feed both views; bits 3:0 feed only the level
  assign lane1_drive_code =
    macro1_ctl_reg[`M1_DRV_LSB +: `M1_DRV_W];
  assign lane1_deemph_on = macro1_ctl_reg[`M1_DEN_BIT];
  assign lane1_deemph_level = {macro1_ctl_reg[13:12],
                               macro1_ctl_reg[9:8],
                               macro1_ctl_reg[3:0]};

  assign lane2_drive_code = macro2_ctl_reg[`M2_DRV_LSB +: 2];
  assign lane2_deemph_on  = macro3_ctl_reg[`M3_DEN2_BIT];
  assign lane2_deemph_level = {macro2_ctl_reg[`M2_DLV_HI_LSB +: 4],
                               macro2_ctl_reg[`M2_DLV_LO_LSB +: 4]};

  assign lane3_drive_code = macro3_ctl_reg[`M3_DRV_LSB +: 2];
  assign lane3_deemph_level = {macro3_ctl_reg[`M3_DLV_HI_LSB +: 7],
                               macro3_ctl_reg[`M3_DLV_LO_BIT]};

endmodule

`default_nettype wire

// *** dv/tx_lane_tuning_checker_assertions.sv ***
// Checker for the lane tuning bank: bus wait and field decode.
// Assumes it is bound to the bank and sees only its ports.
`timescale 1ns/100ps
`default_nettype none

module tx_lane_tuning_checker (
  input wire logic                    ref_clk,
  input wire logic                    rst_n,
  input wire logic [17:0]             address,
  input wire logic                    read,
  input wire logic                    write,
  input wire logic [3:0]              byteenable,
  input wire logic [31:0]             writedata,
  input wire logic [31:0]             readdata,
  input wire logic [1:0]              response,
  input wire logic                    waitrequest,
  input wire tx_lane_pkg::lane_tune_t lane0_tune,
  input wire tx_lane_pkg::lane_tune_t lanes4to7_tune,
  input wire tx_lane_pkg::lane_tune_t lanes8to15_tune,
  input wire logic [11:0]             lane1_drive_code,
  input wire logic                    lane1_deemph_on,
  input wire logic [7:0]              lane1_deemph_level,
  input wire logic [1:0]              lane2_drive_code,
  input wire logic                    lane2_deemph_on,
  input wire logic [7:0]              lane2_deemph_level,
  input wire logic [1:0]              lane3_drive_code,
  input wire logic [7:0]              lane3_deemph_level
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [31:0] wd_q;
  wire logic [74:0] lanes;
  assign lanes = {lane0_tune, lanes4to7_tune, lanes8to15_tune,
    lane1_drive_code, lane1_deemph_on, lane1_deemph_level,
    lane2_drive_code, lane2_deemph_on, lane2_deemph_level,
    lane3_drive_code, lane3_deemph_level};
  // Write data of the answer edge, for checks one cycle later
  always_ff @(posedge ref_clk) begin
    wd_q <= writedata;
  end
  sequence wr_at(a);
    write && !waitrequest && address == a && byteenable == 4'hF;
  endsequence
  req_waits_a: assert property (
    $rose(read || write) |-> waitrequest ##[1:3] !waitrequest)
    else $error("request not answered in time");
  bad_addr_a: assert property (
    read && !waitrequest && address == 18'h00100
    |=> response == 2'h3 && readdata == 32'h0)
    else $error("unmapped read not refused");
  drive_codes_a: assert property (wr_at(18'h0009C)
    |=> {lanes8to15_tune.drive_code, lanes4to7_tune.drive_code,
         lane0_tune.drive_code} == wd_q[21:16])
    else $error("drive codes wrong");
  deemph_grp_a: assert property (wr_at(18'h000B0)
    |=> {lanes8to15_tune.deemph_on, lanes4to7_tune.deemph_on,
         lane0_tune.deemph_on} == wd_q[26:24]
    && {lanes8to15_tune.deemph_level, lanes4to7_tune.deemph_level,
        lane0_tune.deemph_level} == wd_q[23:0])
    else $error("group de-emphasis wrong");
  lane1_a: assert property (wr_at(18'h1FB00)
    |=> lane1_drive_code == wd_q[15:4] && lane1_deemph_on == wd_q[20]
    && lane1_deemph_level == {wd_q[13:12], wd_q[9:8], wd_q[3:0]})
    else $error("lane 1 fields wrong");
  lane2_a: assert property (wr_at(18'h1FB10)
    |=> lane2_drive_code == wd_q[17:16]
    && lane2_deemph_level == {wd_q[15:12], wd_q[7:4]})
    else $error("lane 2 fields wrong");
  lane3_a: assert property (wr_at(18'h1FB20)
    |=> lane3_drive_code == wd_q[17:16] && lane2_deemph_on == wd_q[28]
    && lane3_deemph_level == {wd_q[14:8], wd_q[0]})
    else $error("lane 3 fields wrong");
  lanes_hold_a: assert property (
    !(write && !waitrequest) |=> $stable(lanes))
    else $error("lane outputs moved without a write");
endmodule

bind tx_lane_tuning_regs tx_lane_tuning_checker u_tx_lane_tuning_checker (
  .ref_clk, .rst_n, .address, .read, .write, .byteenable, .writedata,
  .readdata, .response, .waitrequest, .lane0_tune, .lanes4to7_tune,
  .lanes8to15_tune, .lane1_drive_code, .lane1_deemph_on,
  .lane1_deemph_level, .lane2_drive_code, .lane2_deemph_on,
  .lane2_deemph_level, .lane3_drive_code, .lane3_deemph_level);
`default_nettype wire

// *** dv/test_tx_lane_tuning_regs.sv ***
// Bench for the lane tuning bank over Avalon-MM.
// Assumes byte address = 4 x register index.
`timescale 1ns/100ps
`default_nettype none

module test_tx_lane_tuning_regs;
  logic ref_clk, rst_n, read, write, waitrequest, l1e, l2e;
  logic [17:0] address;
  logic [3:0] byteenable;
  logic [31:0] writedata, readdata, q;
  logic [1:0] response, rs, l2d, l3d;
  logic [11:0] l1d;
  logic [7:0] l1v, l2v, l3v;
  tx_lane_pkg::lane_tune_t t0, t4, t8;
  int errors, n_checks;
  logic [17:0] ad [5] = '{18'h0009C, 18'h000B0, 18'h1FB00, 18'h1FB10,
                          18'h1FB20};
  logic [31:0] wd [5] = '{32'h00390000, 32'h05A5C381, 32'h00103A5C,
                          32'h0002B0C0, 32'h10036D01};
  // Enable bit and strength code of each pre-emphasis setting
  logic [8:0] sw [10] = '{9'h0C0, 9'h080, 9'h040, 9'h000, 9'h181,
                          9'h141, 9'h101, 9'h143, 9'h103, 9'h104};

  tx_lane_tuning_regs u_tx_lane_tuning_regs (
    .ref_clk(ref_clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .response(response), .waitrequest(waitrequest),
    .lane0_tune(t0), .lanes4to7_tune(t4), .lanes8to15_tune(t8),
    .lane1_drive_code(l1d), .lane1_deemph_on(l1e),
    .lane1_deemph_level(l1v), .lane2_drive_code(l2d),
    .lane2_deemph_on(l2e), .lane2_deemph_level(l2v),
    .lane3_drive_code(l3d), .lane3_deemph_level(l3v));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Holds the request until waitrequest is low, then releases it
  task automatic xfer(input logic w, input logic [17:0] a,
                      input logic [31:0] d, input logic [3:0] be);
    write <= w;
    read <= !w;
    address <= a;
    writedata <= d;
    byteenable <= be;
    // Only the watchdog ends a wait that never sees an answer
    do begin
      @(posedge ref_clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    rs = response;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [17:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, 4'hF);
    chk(q, e);
  endtask

  task automatic results;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    #200000;
    errors++;
    results;
  end

  initial begin
    {rst_n, read, write, address, byteenable, writedata} = '0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    foreach (ad[i]) rd(ad[i], 32'h0);
    foreach (ad[i]) begin
      xfer(1'b1, ad[i], wd[i], 4'hF);
      rd(ad[i], wd[i]);
    end
    chk({t8.drive_code, t4.drive_code, t0.drive_code}, 6'h39);
    chk({l1d, l2d, l3d}, 16'h3A5B);
    chk({t8.deemph_on, t4.deemph_on, t0.deemph_on}, 3'b101);
    chk({l1e, l2e}, 2'b11);
    chk({t8.deemph_level, t4.deemph_level, t0.deemph_level}, 24'hA5C381);
    chk({l1v, l2v, l3v}, 24'hECBCDB);
    xfer(1'b1, ad[1], 32'hFFFFFFFF, 4'b0100);
    rd(ad[1], 32'h05FFC381);
    xfer(1'b1, 18'h00100, 32'hFFFFFFFF, 4'hF);
    rd(18'h00100, 32'h0);
    chk(rs, 2'h3);
    rd(ad[0], wd[0]);
    chk(rs, 2'h0);
    xfer(1'b1, ad[0], 32'h003F0000, 4'hF);
    foreach (sw[i]) begin
      xfer(1'b1, ad[1], {7'h0, sw[i][8], 16'h0, sw[i][7:0]}, 4'hF);
      chk({t0.deemph_on, t0.deemph_level, t0.drive_code}, {sw[i], 2'b11});
    end
    results;
  end
endmodule
`default_nettype wire
